/* File: design/vmecr_pkg.sv */
// Package for the chained read / multicast slave token logic.
// Assumes one 40 MHz clock, AXI4-Lite register access and raw backplane pins, synchronised in two stages by the slave.

package vmecr_pkg;

	// ----------------------------------------
	// Clock and register map
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BASE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVT_LEN = 8'h0C;
	localparam logic [7:0] OFS_MC_DATA = 8'h10;
	localparam logic [7:0] OFS_MC_COUNT = 8'h14;
	localparam logic [2:0] OFS_EVT_PAGE = 3'h1;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [23:0] BASE_RST = 24'h00_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_CR_EN = 0;
	localparam int CTRL_MC_EN = 1;
	localparam int CTRL_HEAD = 2;
	localparam int CTRL_TAIL = 3;
	localparam int CTRL_ERR_REP = 4;
	localparam int CTRL_ERR_LSB = 8;
	localparam int BASE_CR_LSB = 0;
	localparam int BASE_MC_LSB = 8;
	localparam int BASE_GEO_LSB = 16;
	localparam int STAT_DRAINED = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_ENDED = 2;

	// ----------------------------------------
	// Protocol codes and frame layout
	// ----------------------------------------
	localparam logic [5:0] AM_CR_D32 = 6'h0B;
	localparam logic [5:0] AM_CR_D64 = 6'h08;
	localparam logic [5:0] AM_CR_D32_SUP = 6'h0F;
	localparam logic [5:0] AM_CR_D64_SUP = 6'h0C;
	localparam logic [5:0] AM_MC = 6'h09;
	localparam logic [5:0] AM_MC_SUP = 6'h0D;
	localparam logic [2:0] STATUS_NORMAL = 3'h0;
	localparam logic [2:0] STATUS_ENDED = 3'h1;
	localparam logic [3:0] EVT_MAX = 4'h8;
	localparam logic [3:0] FRAME_EXTRA = 4'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_D64_ADDR, ST_D64_REL, ST_TOKEN, ST_RD_DATA, ST_RD_HOLD,
		ST_RD_END, ST_PASS, ST_MC_TOKEN, ST_MC_ACK, ST_WAIT_AS
	} vmecr_fsm_t;

	typedef struct packed {
		logic as_n;
		logic [1:0] ds_n;
		logic write_n;
		logic iack_n;
		logic iackin_n;
		logic [5:0] am;
		logic [7:0] addr_top;
		logic [31:0] data;
	} vmecr_vin_t;

	typedef struct packed {
		logic iackout_n;
		logic dtack_n;
		logic dtack_oe;
		logic berr_n;
		logic berr_oe;
		logic [31:0] data;
		logic data_oe;
	} vmecr_vout_t;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} vmecr_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vmecr_axi_rsp_t;

endpackage : vmecr_pkg

/* File: design/vmecr_slave.sv */
// Token logic of one module in a chained block read / multicast write chain.
// Assumes backplane pins arrive raw and are resolved by the bench from the enables.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.

`timescale 1ns/1ps

module vmecr_slave
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire vmecr_pkg::vmecr_axi_req_t axi_req,
	output vmecr_pkg::vmecr_axi_rsp_t axi_rsp,
	input wire vmecr_pkg::vmecr_vin_t vme_in,
	output vmecr_pkg::vmecr_vout_t vme_out
);
	import vmecr_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		vmecr_vin_t s1;
		vmecr_vin_t s2;
		vmecr_fsm_t fsm;
		logic [3:0] idx;
		logic drained;
		logic ended;
		logic [15:0] ctrl;
		logic [23:0] base;
		logic [3:0] evt_len;
		logic [7:0][31:0] evt;
		logic [31:0] mc_data;
		logic [15:0] mc_count;
		logic aw_held;
		logic w_held;
		logic [7:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		vmecr_axi_rsp_t rsp;
		vmecr_vout_t out;
	} vmecr_st_t;

	vmecr_st_t q;
	vmecr_st_t next_q;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction : wmerge

	// Words this module supplies; disabled or empty non-tail modules supply none
	function automatic logic [3:0] frame_total(input vmecr_st_t s);
		logic has_data;
		has_data = s.ctrl[CTRL_CR_EN] && (s.evt_len != 4'h0);
		if (!has_data && !s.ctrl[CTRL_TAIL])
			return 4'h0;
		return (has_data ? s.evt_len : 4'h0) + FRAME_EXTRA;
	endfunction : frame_total

	// Header, event words, trailer with status and byte count
	function automatic logic [31:0] frame_word(input vmecr_st_t s);
		logic [2:0] status;
		logic [3:0] total;
		logic [23:0] bytes;
		total = frame_total(s);
		bytes = {18'h0_0000, total, 2'h0};
		status = s.ctrl[CTRL_TAIL] ? STATUS_ENDED : STATUS_NORMAL;
		if (s.ctrl[CTRL_ERR_REP])
			status = s.ctrl[CTRL_ERR_LSB +: 3];
		if (s.idx == 4'h0)
			return {s.base[BASE_GEO_LSB +: 5], 23'h00_0000, s.evt_len};
		if (s.idx == total - 4'h1)
			return {s.base[BASE_GEO_LSB +: 5], status, bytes};
		return s.evt[3'(s.idx - 4'h1)];
	endfunction : frame_word

	wire logic ds_on = (q.s2.ds_n != 2'b11);
	wire logic ds_off = (q.s2.ds_n == 2'b11);
	wire logic is_head = q.ctrl[CTRL_HEAD];
	wire logic is_tail = q.ctrl[CTRL_TAIL];
	wire logic have_token = is_head || !q.s2.iackin_n;
	wire logic am_cr = (q.s2.am == AM_CR_D32) || (q.s2.am == AM_CR_D64) ||
		(q.s2.am == AM_CR_D32_SUP) || (q.s2.am == AM_CR_D64_SUP);
	wire logic am_d64 = (q.s2.am == AM_CR_D64) || (q.s2.am == AM_CR_D64_SUP);
	wire logic am_mc = (q.s2.am == AM_MC) || (q.s2.am == AM_MC_SUP);
	wire logic hit_cr = (q.s2.addr_top == q.base[BASE_CR_LSB +: 8]) && am_cr;
	wire logic hit_mc = (q.s2.addr_top == q.base[BASE_MC_LSB +: 8]) && am_mc;

	assign axi_rsp = q.rsp;
	assign vme_out = q.out;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.s1 = vme_in;
		next_q.s2 = q.s1;
		// Write channels are taken independently
		if (axi_req.awvalid && q.rsp.awready)
		begin
			next_q.aw_held = 1'b1;
			next_q.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready)
		begin
			next_q.w_held = 1'b1;
			next_q.wdata = axi_req.wdata;
			next_q.wstrb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready)
			next_q.rsp.bvalid = 1'b0;
		// Register write once both halves are held
		if (q.aw_held && q.w_held && !q.rsp.bvalid)
		begin
			next_q.aw_held = 1'b0;
			next_q.w_held = 1'b0;
			next_q.rsp.bvalid = 1'b1;
			next_q.rsp.bresp = RESP_OKAY;
			if (q.aw_addr[7:5] == OFS_EVT_PAGE && q.aw_addr[1:0] == 2'h0)
				next_q.evt[q.aw_addr[4:2]] = wmerge(q.evt[q.aw_addr[4:2]], q.wdata, q.wstrb);
			else
			begin
				case (q.aw_addr)
					OFS_CTRL: next_q.ctrl = 16'(wmerge({16'h0000, q.ctrl}, q.wdata, q.wstrb));
					OFS_BASE: next_q.base = 24'(wmerge({8'h00, q.base}, q.wdata, q.wstrb));
					OFS_STATUS:
					begin
						if (q.wstrb[0] && q.wdata[STAT_DRAINED])
							next_q.drained = 1'b0;
						if (q.wstrb[0] && q.wdata[STAT_ENDED])
							next_q.ended = 1'b0;
					end
					OFS_EVT_LEN:
					begin
						if (q.wstrb[0])
						begin
							next_q.evt_len = (q.wdata[7:0] > 8'(EVT_MAX)) ? EVT_MAX : q.wdata[3:0];
							next_q.drained = 1'b0;
							next_q.idx = 4'h0;
						end
					end
					OFS_MC_DATA, OFS_MC_COUNT: next_q.rsp.bresp = RESP_OKAY;
					default: next_q.rsp.bresp = RESP_SLVERR;
				endcase
			end
		end
		// Read channel, answered on the same edge that takes the address
		if (q.rsp.rvalid && axi_req.rready)
			next_q.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && q.rsp.arready)
		begin
			next_q.rsp.rvalid = 1'b1;
			next_q.rsp.rresp = RESP_OKAY;
			next_q.rsp.rdata = 32'h0000_0000;
			if (axi_req.araddr[7:5] == OFS_EVT_PAGE && axi_req.araddr[1:0] == 2'h0)
				next_q.rsp.rdata = q.evt[axi_req.araddr[4:2]];
			else
			begin
				case (axi_req.araddr)
					OFS_CTRL: next_q.rsp.rdata = {16'h0000, q.ctrl};
					OFS_BASE: next_q.rsp.rdata = {8'h00, q.base};
					OFS_STATUS: next_q.rsp.rdata = {24'h00_0000, q.idx, 1'b0, q.ended,
						(q.evt_len == 4'h0), q.drained};
					OFS_EVT_LEN: next_q.rsp.rdata = {28'h000_0000, q.evt_len};
					OFS_MC_DATA: next_q.rsp.rdata = q.mc_data;
					OFS_MC_COUNT: next_q.rsp.rdata = {16'h0000, q.mc_count};
					default: next_q.rsp.rresp = RESP_SLVERR;
				endcase
			end
		end
		// Backplane token machine
		case (q.fsm)
			ST_IDLE:
			begin
				if (!q.s2.as_n && q.s2.iack_n)
				begin
					if (hit_cr && q.s2.write_n)
						next_q.fsm = am_d64 ? ST_D64_ADDR : ST_TOKEN;
					else if (hit_mc && !q.s2.write_n)
						next_q.fsm = ST_MC_TOKEN;
					else
						next_q.fsm = ST_WAIT_AS;
				end
			end
			ST_D64_ADDR:
			begin
				if (ds_on)
				begin
					next_q.out.dtack_oe = is_tail;
					next_q.fsm = ST_D64_REL;
				end
			end
			ST_D64_REL:
			begin
				if (ds_off)
				begin
					next_q.out.dtack_oe = 1'b0;
					next_q.fsm = ST_TOKEN;
				end
			end
			ST_TOKEN:
			begin
				if (have_token)
				begin
					if (!q.drained && frame_total(q) != 4'h0)
						next_q.fsm = ST_RD_DATA;
					else if (is_tail)
						next_q.fsm = ST_RD_END;
					else
					begin
						next_q.out.iackout_n = 1'b0;
						next_q.fsm = ST_PASS;
					end
				end
			end
			ST_RD_DATA:
			begin
				if (ds_on)
				begin
					next_q.out.data = frame_word(q);
					next_q.out.data_oe = 1'b1;
					next_q.out.dtack_oe = 1'b1;
					next_q.fsm = ST_RD_HOLD;
				end
			end
			ST_RD_HOLD:
			begin
				if (ds_off)
				begin
					next_q.out.dtack_oe = 1'b0;
					next_q.out.data_oe = 1'b0;
					next_q.idx = q.idx + 4'h1;
					next_q.fsm = ST_RD_DATA;
					if (q.idx + 4'h1 == frame_total(q))
					begin
						next_q.drained = 1'b1;
						next_q.idx = 4'h0;
						next_q.fsm = is_tail ? ST_RD_END : ST_PASS;
						next_q.out.iackout_n = is_tail;
					end
				end
			end
			ST_RD_END:
			begin
				if (ds_on && is_tail)
				begin
					next_q.out.berr_oe = 1'b1;
					next_q.ended = 1'b1;
				end
			end
			ST_MC_TOKEN:
			begin
				if (have_token && ds_on)
				begin
					if (q.ctrl[CTRL_MC_EN])
					begin
						next_q.mc_data = q.s2.data;
						next_q.mc_count = q.mc_count + 16'h0001;
					end
					next_q.out.dtack_oe = is_tail;
					next_q.out.iackout_n = is_tail;
					next_q.fsm = is_tail ? ST_MC_ACK : ST_PASS;
				end
			end
			ST_MC_ACK:
			begin
				if (ds_off)
				begin
					next_q.out.dtack_oe = 1'b0;
					next_q.fsm = ST_WAIT_AS;
				end
			end
			ST_PASS, ST_WAIT_AS: next_q.fsm = q.fsm;
			default: next_q.fsm = ST_IDLE;
		endcase
		// End of cycle withdraws every drive
		if (q.fsm != ST_IDLE && q.s2.as_n)
		begin
			next_q.fsm = ST_IDLE;
			next_q.out.iackout_n = 1'b1;
			next_q.out.dtack_oe = 1'b0;
			next_q.out.berr_oe = 1'b0;
			next_q.out.data_oe = 1'b0;
		end
		// Interrupt acknowledge daisy chain
		if (!q.s2.iack_n)
			next_q.out.iackout_n = q.s2.iackin_n;
		next_q.rsp.awready = !next_q.aw_held && !next_q.rsp.bvalid;
		next_q.rsp.wready = !next_q.w_held && !next_q.rsp.bvalid;
		next_q.rsp.arready = !next_q.rsp.rvalid;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.s1 <= '1;
			q.s2 <= '1;
			q.fsm <= ST_IDLE;
			q.ctrl <= CTRL_RST;
			q.base <= BASE_RST;
			q.out.iackout_n <= 1'b1;
		end
		else
			q <= next_q;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tail_no_pass: assert property ((is_tail && q.s2.iack_n && q.fsm != ST_IDLE)
		|-> q.out.iackout_n) else $error("tail passed the token");
	a_pass_after_ds: assert property ((q.fsm == ST_RD_HOLD && ds_off && !q.s2.as_n
		&& q.s2.iack_n && !is_tail && q.idx + 4'h1 == frame_total(q))
		|=> (!q.out.iackout_n && q.fsm == ST_PASS)) else $error("token pass missing");
	a_berr_tail: assert property (q.out.berr_oe |-> is_tail) else $error("bus error by non-tail");
	a_berr_after: assert property ($rose(q.out.berr_oe) |-> (q.ended && q.drained
		&& $past(q.fsm) == ST_RD_END)) else $error("bus error before frame end");
	a_mc_ack: assert property (($rose(q.out.dtack_oe) && q.fsm == ST_MC_ACK)
		|-> $past(have_token && ds_on)) else $error("multicast ack without token");
	a_mc_read: assert property ((q.fsm == ST_IDLE && !q.s2.as_n && q.s2.iack_n && hit_mc
		&& q.s2.write_n) |=> (!q.out.dtack_oe && !q.out.berr_oe && !q.out.data_oe) [*2])
		else $error("multicast read answered");
	a_as_release: assert property ((q.fsm != ST_IDLE && q.s2.as_n && q.s2.iack_n)
		|=> (q.out.iackout_n && !q.out.dtack_oe && !q.out.berr_oe))
		else $error("drive kept after strobe release");
	a_iack_pass: assert property (!q.s2.iack_n |=> q.out.iackout_n == $past(q.s2.iackin_n))
		else $error("daisy chain not passed");
	a_head_start: assert property ((q.fsm == ST_TOKEN && is_head && !q.drained
		&& frame_total(q) != 4'h0 && !q.s2.as_n) |=> q.fsm == ST_RD_DATA)
		else $error("head waited for token");
	a_d64_silent: assert property (((q.fsm == ST_D64_ADDR || q.fsm == ST_D64_REL) && !is_tail)
		|-> !q.out.dtack_oe) else $error("non-tail acked address phase");
	a_drained_skip: assert property ((q.fsm == ST_TOKEN && q.drained && !is_tail
		&& !q.s2.iackin_n && !q.s2.as_n && q.s2.iack_n) |=> !q.out.iackout_n)
		else $error("drained module held token");

	c_read_end: cover property ($rose(q.out.berr_oe));
	c_read_pass: cover property (q.fsm == ST_RD_HOLD ##1 q.fsm == ST_PASS);
	c_mc_ack: cover property ($rose(q.out.dtack_oe) && q.fsm == ST_MC_ACK);
	c_mc_pass: cover property (q.fsm == ST_MC_TOKEN ##1 q.fsm == ST_PASS);

endmodule : vmecr_slave

/* File: test/vmecr_vme_model.sv */
// VME master and upstream chain neighbour model for the token logic bench.
// Assumes the bench calls its tasks from one process, one cycle at a time.
`timescale 1ns/1ps

module vmecr_vme_model
(
	input wire logic aclk,
	input wire vmecr_pkg::vmecr_vout_t vme_out,
	output vmecr_pkg::vmecr_vin_t vme_in
);
	import vmecr_pkg::*;
	vmecr_vin_t pin = '{1'b1, 2'b11, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00, 32'h0000_0000};
	logic [31:0] junk = 32'h5a5a_a5a5;
	logic drv = 1'b0;

	// Released data lines toggle every cycle
	always @(posedge aclk)
		junk <= ~junk;

	// Bus data: slave drive, else master write data, else junk
	always_comb
	begin
		vme_in = pin;
		vme_in.data = vme_out.data_oe ? vme_out.data : (drv ? pin.data : junk);
	end

	// ----------------------------------------
	// Cycle tasks
	// ----------------------------------------
	// Address first, then address strobe
	task automatic start(input logic [7:0] a, input logic [5:0] m, input logic wr_n);
		@(posedge aclk);
		pin.addr_top <= a;
		pin.am <= m;
		pin.write_n <= wr_n;
		@(posedge aclk);
		pin.as_n <= 1'b0;
	endtask : start

	// Acknowledge line and chain input
	task automatic chain(input logic iack_l, input logic in_l);
		@(posedge aclk);
		pin.iack_n <= iack_l;
		pin.iackin_n <= in_l;
	endtask : chain

	// One strobe pair; ends on acknowledge or bus error, cut short after 40
	task automatic strobe(input logic [31:0] d, output logic ack, output logic err,
		output logic [31:0] q, output logic io);
		int n;
		n = 0;
		@(posedge aclk);
		pin.data <= d;
		drv <= ~pin.write_n;
		pin.ds_n <= 2'b00;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (vme_out.dtack_oe !== 1'b1 && vme_out.berr_oe !== 1'b1 && n < 40);
		ack = vme_out.dtack_oe;
		err = vme_out.berr_oe;
		q = vme_in.data;
		io = vme_out.iackout_n;
		pin.ds_n <= 2'b11;
		while (vme_out.dtack_oe === 1'b1 && n < 80)
		begin
			@(posedge aclk);
			n++;
		end
		drv <= 1'b0;
	endtask : strobe

	// Address strobe release ends the cycle
	task automatic stop();
		@(posedge aclk);
		pin.as_n <= 1'b1;
		pin.iackin_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : stop
endmodule : vmecr_vme_model

/* File: test/test_vme_chain_readout_multicast_slave.sv */
// Self-checking bench for the chained read and multicast token logic.
// Assumes the VME model stands in for the master and the upstream module.
`timescale 1ns/1ps

module test_vme_chain_readout_multicast_slave;
	import vmecr_pkg::*;
	localparam logic [4:0] GEO = 5'h13;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	vmecr_axi_req_t req = '0;
	vmecr_axi_rsp_t rsp;
	vmecr_vin_t vin;
	vmecr_vout_t vout;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] q;
	logic [1:0] r;
	logic ack;
	logic err;
	logic io;

	vmecr_slave i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.vme_in(vin), .vme_out(vout));
	vmecr_vme_model i_vme (.aclk(aclk), .vme_out(vout), .vme_in(vin));

	// 40 MHz clock
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write word; address and data offered together, response checked
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk(rsp.bresp, e);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		d = rsp.rdata;
		s = rsp.rresp;
	endtask : axi_rd

	// Role bits, bases and a one-word event
	task automatic setup(input logic [31:0] ctrl);
		axi_wr(OFS_CTRL, ctrl, RESP_OKAY);
		axi_wr(OFS_BASE, 32'h0013_c3a5, RESP_OKAY);
		axi_wr(8'h20, 32'h1234_5678, RESP_OKAY);
		axi_wr(OFS_EVT_LEN, 32'h0000_0001, RESP_OKAY);
	endtask : setup

	// Header, one word, trailer with the given status
	task automatic rd_frame(input logic [2:0] st);
		logic [31:0] exp [3];
		exp = '{{GEO, 23'h0, 4'h1}, 32'h1234_5678, {GEO, st, 24'h00_000c}};
		foreach (exp[i])
		begin
			i_vme.strobe(32'h0000_0000, ack, err, q, io);
			chk({ack, io}, 2'b11);
			chk(q, exp[i]);
		end
	endtask : rd_frame

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	task automatic t_regs();
		axi_rd(OFS_CTRL, q, r);
		chk(q, {16'h0000, CTRL_RST});
		axi_rd(OFS_STATUS, q, r);
		chk(q, 32'h0000_0002); // Only the empty flag after reset
		chk({vout.dtack_n, vout.berr_n}, 2'b00);
		axi_rd(8'h18, q, r);
		chk({q, r}, {32'h0000_0000, RESP_SLVERR});
		axi_wr(8'h18, 32'hffff_ffff, RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs

	// Head and tail in one module, every chained read code
	task automatic t_tail();
		logic [5:0] ams [4];
		ams = '{AM_CR_D32, AM_CR_D64, AM_CR_D32_SUP, AM_CR_D64_SUP};
		foreach (ams[i])
		begin
			setup((i == 3) ? 32'h0000_051f : 32'h0000_000f);
			i_vme.start(8'ha5, ams[i], 1'b1);
			if (ams[i] == AM_CR_D64 || ams[i] == AM_CR_D64_SUP)
			begin
				i_vme.strobe(32'h0000_0000, ack, err, q, io);
				chk({ack, err}, 2'b10);
			end
			rd_frame((i == 3) ? 3'h5 : STATUS_ENDED);
			i_vme.strobe(32'h0000_0000, ack, err, q, io);
			chk({ack, err, io}, 3'b011);
			i_vme.stop();
			axi_rd(OFS_STATUS, q, r);
			chk(q[2:0], 3'b101);
		end
		$display("test tail done");
	endtask : t_tail

	// Head passes on after its frame, then, with the head bit cleared, skips once drained
	task automatic t_pass();
		setup(32'h0000_0007);
		i_vme.start(8'ha5, AM_CR_D32, 1'b1);
		rd_frame(STATUS_NORMAL);
		chk(vout.iackout_n, 1'b0);
		i_vme.strobe(32'h0000_0000, ack, err, q, io);
		chk({ack, err}, 2'b00);
		i_vme.stop();
		chk(vout.iackout_n, 1'b1);
		axi_wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
		i_vme.start(8'ha5, AM_CR_D64, 1'b1);
		i_vme.chain(1'b1, 1'b0);
		repeat (6) @(posedge aclk);
		chk(vout.iackout_n, 1'b1);
		i_vme.strobe(32'h0000_0000, ack, err, q, io);
		chk({ack, err}, 2'b00);
		repeat (6) @(posedge aclk);
		chk(vout.iackout_n, 1'b0);
		i_vme.stop();
		axi_wr(OFS_EVT_LEN, 32'h0000_0001, RESP_OKAY);
		axi_rd(OFS_STATUS, q, r);
		chk(q[0], 1'b0);
		// Chain read disabled: module counts as empty and passes at once
		axi_wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
		i_vme.start(8'ha5, AM_CR_D32, 1'b1);
		i_vme.chain(1'b1, 1'b0);
		repeat (6) @(posedge aclk);
		chk(vout.iackout_n, 1'b0);
		i_vme.stop();
		$display("test pass done");
	endtask : t_pass

	task automatic t_mcast();
		setup(32'h0000_000b);
		i_vme.start(8'hc3, AM_MC, 1'b0);
		i_vme.chain(1'b1, 1'b0);
		i_vme.strobe(32'hcafe_0001, ack, err, q, io);
		chk({ack, err, io}, 3'b101);
		i_vme.stop();
		axi_rd(OFS_MC_DATA, q, r);
		chk(q, 32'hcafe_0001);
		axi_wr(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
		i_vme.start(8'hc3, AM_MC_SUP, 1'b0);
		i_vme.strobe(32'hcafe_0002, ack, err, q, io);
		chk({ack, err, vout.iackout_n}, 3'b000);
		i_vme.stop();
		axi_rd(OFS_MC_DATA, q, r);
		chk(q, 32'hcafe_0002);
		i_vme.start(8'hc3, AM_MC, 1'b1);
		i_vme.strobe(32'h0000_0000, ack, err, q, io);
		chk({ack, err, vout.data_oe}, 3'b000);
		i_vme.stop();
		$display("test mcast done");
	endtask : t_mcast

	task automatic t_iack();
		i_vme.chain(1'b0, 1'b0);
		repeat (6) @(posedge aclk);
		chk(vout.iackout_n, 1'b0);
		i_vme.chain(1'b0, 1'b1);
		repeat (6) @(posedge aclk);
		chk(vout.iackout_n, 1'b1);
		i_vme.chain(1'b1, 1'b1);
		$display("test iack done");
	endtask : t_iack

	// Main sequence
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_tail();
		t_pass();
		t_mcast();
		t_iack();
		give_verdict();
	end
endmodule : test_vme_chain_readout_multicast_slave
